// >>> hw/ocs_pkg.sv
package ocs_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int OCS_ADR_W = 8;
    localparam int OCS_DAT_W = 32;
    localparam int OCS_CFG_WORDS = 4;
    localparam int OCS_CFG_BITS = 128;
    localparam logic [OCS_ADR_W-1:0] OCS_OFS_CFG0 = 8'h00;
    localparam logic [OCS_ADR_W-1:0] OCS_OFS_CFG1 = 8'h04;
    localparam logic [OCS_ADR_W-1:0] OCS_OFS_CFG2 = 8'h08;
    localparam logic [OCS_ADR_W-1:0] OCS_OFS_CFG3 = 8'h0C;
    localparam logic [OCS_ADR_W-1:0] OCS_OFS_STATUS = 8'h10;
    localparam logic [OCS_DAT_W-1:0] OCS_CFG_RESET = 32'h00000000;
    localparam logic [OCS_DAT_W-1:0] OCS_RD_UNMAPPED = 32'h00000000;

    // ------------------------------------------------------------
    // source select fields in the 128-bit configuration word
    // ------------------------------------------------------------
    localparam int OCS_POS_A = 22;
    localparam int OCS_POS_B = 46;
    localparam int OCS_POS_C_PRI = 70;
    localparam int OCS_POS_C_ALT = 124;
    localparam int OCS_POS_D_PRI = 94;
    localparam int OCS_POS_D_ALT = 126;

    // status word layout
    localparam int OCS_ST_POS_A = 0;
    localparam int OCS_ST_POS_B = 2;
    localparam int OCS_ST_POS_C = 4;
    localparam int OCS_ST_POS_D = 6;
    localparam int OCS_ST_POS_PIN = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCS_SRC_REF = 2'b00,
        OCS_SRC_PLL_A = 2'b01,
        OCS_SRC_PLL_B = 2'b10,
        OCS_SRC_PLL_C = 2'b11
    } ocs_src_e;

    typedef struct packed {
        ocs_src_e path_a;
        ocs_src_e path_b;
        ocs_src_e path_c;
        ocs_src_e path_d;
    } ocs_path_sel_s;

    localparam ocs_path_sel_s OCS_PATH_SEL_RESET = '{
        OCS_SRC_REF, OCS_SRC_REF, OCS_SRC_REF, OCS_SRC_REF
    };

endpackage

// >>> hw/ocs_top.sv
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ocs_top
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ocs_pkg::OCS_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [ocs_pkg::OCS_DAT_W-1:0] WB_DAT_I,
    output logic [ocs_pkg::OCS_DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic CLOCK_SET_SELECT_PIN,
    output ocs_pkg::ocs_path_sel_s PATH_SRC_SEL
);
    import ocs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [OCS_DAT_W-1:0] cfg_reg [OCS_CFG_WORDS];
    logic [OCS_DAT_W-1:0] cfg_next [OCS_CFG_WORDS];
    logic ack_reg;
    logic ack_next;
    logic [OCS_DAT_W-1:0] rdat_reg;
    logic [OCS_DAT_W-1:0] rdat_next;
    ocs_path_sel_s sel_reg;
    ocs_path_sel_s sel_next;
    logic pin_reg;
    logic pin_next;

    logic [OCS_CFG_BITS-1:0] cfg_flat;
    logic take;
    logic [1:0] word_idx;
    logic cfg_hit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge for a Wishbone write
    function automatic logic [OCS_DAT_W-1:0] merge_bytes(
        input logic [OCS_DAT_W-1:0] old_val,
        input logic [OCS_DAT_W-1:0] new_val,
        input logic [3:0] sel
    );
        logic [OCS_DAT_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // word n holds configuration bits 32n+31 down to 32n
    assign cfg_flat = {cfg_reg[3], cfg_reg[2], cfg_reg[1], cfg_reg[0]};
    // a new request is taken only while ack is low, so ack lasts one cycle
    assign take = WB_CYC_I && WB_STB_I && !ack_reg;
    assign word_idx = WB_ADR_I[3:2];
    assign cfg_hit = (WB_ADR_I == OCS_OFS_CFG0) ||
                     (WB_ADR_I == OCS_OFS_CFG1) ||
                     (WB_ADR_I == OCS_OFS_CFG2) ||
                     (WB_ADR_I == OCS_OFS_CFG3);

    // ------------------------------------------------------------
    // register file and bus slave
    // ------------------------------------------------------------
    always_comb
    begin
        for (int w = 0; w < OCS_CFG_WORDS; w++)
        begin
            cfg_next[w] = cfg_reg[w];
        end
        ack_next = take;
        rdat_next = rdat_reg;
        if (take)
        begin
            if (WB_WE_I)
            begin
                // status word is read-only; writes elsewhere are dropped
                // they are still acked, so a master never stalls on a bad address
                if (cfg_hit)
                begin
                    cfg_next[word_idx] = merge_bytes(cfg_reg[word_idx], WB_DAT_I, WB_SEL_I);
                end
                rdat_next = OCS_RD_UNMAPPED;
            end
            else if (cfg_hit)
            begin
                rdat_next = cfg_reg[word_idx];
            end
            else if (WB_ADR_I == OCS_OFS_STATUS)
            begin
                // shows the selects actually driven, not the raw fields
                rdat_next = OCS_RD_UNMAPPED;
                rdat_next[OCS_ST_POS_A +: 2] = sel_reg.path_a;
                rdat_next[OCS_ST_POS_B +: 2] = sel_reg.path_b;
                rdat_next[OCS_ST_POS_C +: 2] = sel_reg.path_c;
                rdat_next[OCS_ST_POS_D +: 2] = sel_reg.path_d;
                rdat_next[OCS_ST_POS_PIN] = pin_reg;
            end
            else
            begin
                rdat_next = OCS_RD_UNMAPPED;
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            for (int w = 0; w < OCS_CFG_WORDS; w++)
            begin
                cfg_reg[w] <= OCS_CFG_RESET;
            end
            ack_reg <= 1'b0;
            rdat_reg <= OCS_RD_UNMAPPED;
        end
        else
        begin
            for (int w = 0; w < OCS_CFG_WORDS; w++)
            begin
                cfg_reg[w] <= cfg_next[w];
            end
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // ------------------------------------------------------------
    // source fields of the configuration word
    // ------------------------------------------------------------
    ocs_src_e path_a_source_sel;
    ocs_src_e path_b_source_sel;
    ocs_src_e path_c_source_sel_primary;
    ocs_src_e path_c_source_sel_alternate;
    ocs_src_e path_d_source_sel_primary;
    ocs_src_e path_d_source_sel_alternate;
    logic clock_set_select_pin;

    assign path_a_source_sel = ocs_src_e'(cfg_flat[OCS_POS_A +: 2]);
    assign path_b_source_sel = ocs_src_e'(cfg_flat[OCS_POS_B +: 2]);
    assign path_c_source_sel_primary = ocs_src_e'(cfg_flat[OCS_POS_C_PRI +: 2]);
    assign path_d_source_sel_primary = ocs_src_e'(cfg_flat[OCS_POS_D_PRI +: 2]);
    assign path_c_source_sel_alternate = ocs_src_e'(cfg_flat[OCS_POS_C_ALT +: 2]);
    assign path_d_source_sel_alternate = ocs_src_e'(cfg_flat[OCS_POS_D_ALT +: 2]);
    // used as it comes: the pin must already be synchronous to REF_CLK
    assign clock_set_select_pin = CLOCK_SET_SELECT_PIN;

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    // both field sets stay decoded, so a pin flip needs no config write
    always_comb
    begin
        pin_next = clock_set_select_pin;
        sel_next.path_a = path_a_source_sel;
        sel_next.path_b = path_b_source_sel;
        if (clock_set_select_pin)
        begin
            sel_next.path_c = path_c_source_sel_alternate;
            sel_next.path_d = path_d_source_sel_alternate;
        end
        else
        begin
            sel_next.path_c = path_c_source_sel_primary;
            sel_next.path_d = path_d_source_sel_primary;
        end
    end

    // selects are registered so a glitch-free code reaches the clock muxes
    // the muxes themselves must still switch without runt pulses
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            sel_reg <= OCS_PATH_SEL_RESET;
            pin_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next;
            pin_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;
    assign PATH_SRC_SEL = sel_reg;

endmodule

`default_nettype wire

// >>> tb/ocs_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ocs_chk
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic CLOCK_SET_SELECT_PIN,
    input wire ocs_pkg::ocs_path_sel_s PATH_SRC_SEL
);
    logic [127:0] cfg_reg;
    logic [127:0] cfg_next;
    logic run_reg;
    logic wr;
    // shadow of the config words, so each select traces to its exact bits
    assign wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I
        && WB_ADR_I[7:4] == 4'h0 && WB_ADR_I[1:0] == 2'h0;
    always_comb
    begin
        cfg_next = cfg_reg;
        for (int i = 0; i < 4; i++)
            if (wr && WB_SEL_I[i])
                cfg_next[WB_ADR_I[3:2] * 32 + i * 8 +: 8] = WB_DAT_I[i * 8 +: 8];
    end
    always_ff @(posedge REF_CLK)
    begin
        cfg_reg <= RST ? 128'h0 : cfg_next;
        run_reg <= !RST;
    end
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    path_a_a: assert property (run_reg |-> PATH_SRC_SEL.path_a == $past(cfg_reg[23:22]))
        else $error("path a select wrong");
    path_b_a: assert property (run_reg |-> PATH_SRC_SEL.path_b == $past(cfg_reg[47:46]))
        else $error("path b select wrong");
    path_c_pri_a: assert property (run_reg && !$past(CLOCK_SET_SELECT_PIN) |->
        PATH_SRC_SEL.path_c == $past(cfg_reg[71:70])) else $error("path c select wrong");
    path_c_alt_a: assert property (run_reg && $past(CLOCK_SET_SELECT_PIN) |->
        PATH_SRC_SEL.path_c == $past(cfg_reg[125:124])) else $error("path c select wrong");
    path_d_pri_a: assert property (run_reg && !$past(CLOCK_SET_SELECT_PIN) |->
        PATH_SRC_SEL.path_d == $past(cfg_reg[95:94])) else $error("path d select wrong");
    path_d_alt_a: assert property (run_reg && $past(CLOCK_SET_SELECT_PIN) |->
        PATH_SRC_SEL.path_d == $past(cfg_reg[127:126])) else $error("path d select wrong");
endmodule
bind ocs_top ocs_chk u_chk (.*);
`default_nettype wire

// >>> tb/tb_ocs_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ocs_top;
    import ocs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic pin = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat_r;
    logic ack;
    ocs_path_sel_s path;
    int bad_count = 0;
    int total_checks = 0;
    ocs_top DUT (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .CLOCK_SET_SELECT_PIN(pin), .PATH_SRC_SEL(path));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        check(32'(ack), 32'h1);
        if (ack !== 1'b1)
            print_verdict();
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        // ack must stand for one cycle only
        check(32'(ack), 32'h0);
    endtask
    task automatic s_fields();
        logic [31:0] q;
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            // neighbours set to ones so a shifted field shows up
            wb(1'b1, OCS_OFS_CFG0, {8'hFF, c, 22'h3FFFFF}, q);
            wb(1'b1, OCS_OFS_CFG1, {16'hFFFF, c + 2'h1, 14'h3FFF}, q);
            wb(1'b1, OCS_OFS_CFG2, {c + 2'h3, 22'h3FFFFF, c + 2'h2, 6'h3F}, q);
            wb(1'b1, OCS_OFS_CFG3, {c ^ 2'h1, ~c, 28'hFFFFFFF}, q);
            for (int p = 0; p < 2; p++)
            begin
                pin <= p[0];
                repeat (2) @(posedge clk);
                check(32'(path), p ? {c, c + 2'h1, ~c, c ^ 2'h1}
                    : {c, c + 2'h1, c + 2'h2, c + 2'h3});
            end
        end
    endtask
    task automatic s_bus();
        logic [31:0] q;
        check(32'(path), 32'h0);
        wb(1'b0, OCS_OFS_CFG1, 32'h0, q);
        check(q, OCS_CFG_RESET);
        s_fields();
        wb(1'b1, OCS_OFS_STATUS, 32'h0, q);
        wb(1'b1, 8'h20, 32'h0, q);
        wb(1'b1, 8'h0E, 32'h0, q);
        wb(1'b0, OCS_OFS_CFG3, 32'h0, q);
        check(q, 32'h8FFFFFFF);
        wb(1'b0, 8'h20, 32'h0, q);
        check(q, OCS_RD_UNMAPPED);
        wb(1'b0, OCS_OFS_STATUS, 32'h0, q);
        // last pass left code 3 with the pin high
        check(q, 32'h00000183);
    endtask
    task automatic s_lanes();
        logic [31:0] q;
        // only byte 2 enabled: path A clears, its neighbour bytes stay ones
        sel <= 4'h4;
        wb(1'b1, OCS_OFS_CFG0, 32'h0, q);
        check(q, OCS_RD_UNMAPPED);
        sel <= 4'hF;
        wb(1'b0, OCS_OFS_CFG0, 32'h0, q);
        check(q, 32'hFF00FFFF);
        check(32'(path), 32'h02);
    endtask
    task automatic s_reset();
        logic [31:0] q;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(path), 32'h0);
        wb(1'b0, OCS_OFS_CFG3, 32'h0, q);
        check(q, OCS_CFG_RESET);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_bus();
        s_lanes();
        s_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
